// [pkg/line_camera_defs.vh]
/*
 * Constants for the line camera video port: link input positions,
 * exposure and output mode codes, reset values and trigger timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LINE_CAMERA_DEFS_VH
`define LINE_CAMERA_DEFS_VH

// Link transmitter input positions of the data ports in use
`define TX_A0           5'h00
`define TX_A1           5'h01
`define TX_A2           5'h02
`define TX_A3           5'h03
`define TX_A4           5'h04
`define TX_A5           5'h06
`define TX_A6           5'h1b
`define TX_A7           5'h05
`define TX_B0           5'h07
`define TX_B1           5'h08
`define TX_DVAL         5'h1a
`define TX_LVAL         5'h18
`define TX_WIDTH        28
`define TX_RESET        28'h0000000

// Exposure control modes
`define EXP_EDGE        2'h0
`define EXP_LEVEL       2'h1
`define EXP_PROG        2'h2

// Output mapping modes
`define OUT_10BIT       1'h0
`define OUT_8BIT        1'h1

// Pixel and trigger timing
`define PIX_BITS        10
`define CLK_PERIOD_PS   25000
`define TRIG_HIGH_MIN_PS 100000
`define TRIG_HIGH_MIN_CYC ((`TRIG_HIGH_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// [rtl/trigger_sync.v]
/*
 * Two-stage synchroniser for the line trigger with edge detection.
 * Assumes the trigger is asynchronous to ref_clk and that the trigger
 * period is many clock cycles long.
 */
`timescale 1ns/100ps

module trigger_sync (
    // Clock and control
    input  wire ref_clk,
    input  wire srst,
    input  wire clkEn,
    // Asynchronous trigger level
    input  wire trigAsync,
    // Synchronised level and one-cycle edge pulses
    output wire trigLevel,
    output wire trigRise,
    output wire trigFall
);

    reg meta;
    reg sync;
    reg last;

    // Only the second stage feeds the edge detector
    always @(posedge ref_clk) begin
        if (srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else if (clkEn) begin
            meta <= trigAsync;
            sync <= meta;
            last <= sync;
        end
    end

    assign trigLevel = sync;
    assign trigRise  = clkEn & sync & ~last;
    assign trigFall  = clkEn & ~sync & last;

endmodule

// [rtl/line_camera_video_port.v]
/*
 * Video output port and line-trigger input of a line-scan camera.
 * Drives pixel bits, line valid and data valid onto the link transmitter
 * inputs, forwards the pixel clock, and runs exposure and line readout
 * from the line trigger. Assumes a sensor source on ref_clk that answers
 * pixReq with a pixel on pixIn in the same cycle, and mode inputs that
 * come from logic on ref_clk.
 */
`timescale 1ns/100ps
`include "line_camera_defs.vh"

// Overview of operation
// - Line trigger is the sole control input; no other control line exists.
// - Trigger starts line readout and governs that line's exposure.
// - Edge, level and programmable exposure modes are selectable.
// - One line is produced per trigger period.
// - Only trigger edges act; a static level does nothing.
// - Pixel clock is forwarded to the transmitter clock input.
// - Pixel data, line valid and data valid change on rising clock edge.
// - Pixel clock runs at 20, 40 or 60 MHz by speed grade.
// - Line valid is high for the whole line and low otherwise.
// - Data counts only when line valid and data valid are both high.
// - Port A5, A6, A7 sit on transmitter inputs 6, 27, 5.
// - 10-bit uses A0-A7 and B0-B1; 8-bit uses A0-A7; rest unused.
// - Data valid on input 26, line valid on 24; 23, 25 unused.
// - Exactly one pixel per clock with its valid bits.
// - 8-bit mode sends the upper eight bits of each pixel.
module line_camera_video_port (
    // Clock, reset, enable
    input  wire                   ref_clk,
    input  wire                   srst,
    input  wire                   clkEn,
    // Line trigger from the frame grabber
    input  wire                   lineTrigger,
    // Mode selection
    input  wire [1:0]             expMode,
    input  wire                   outMode8,
    input  wire [15:0]            expTime,
    input  wire [11:0]            lineLength,
    // Sensor pixel source
    output wire                   pixReq,
    input  wire [`PIX_BITS-1:0]   pixIn,
    // Link transmitter inputs
    output wire                   txClk,
    output reg  [`TX_WIDTH-1:0]   txData,
    // Status
    output reg                    exposing,
    output reg                    lineOverrun,
    output reg                    trigTooShort
);

    localparam EX_IDLE = 2'b01;
    localparam EX_RUN  = 2'b10;
    localparam RD_IDLE = 2'b01;
    localparam RD_LINE = 2'b10;

    // Positions of the data ports, A0 in the low field
    localparam [49:0] PORT_POS = {`TX_B1, `TX_B0, `TX_A7, `TX_A6, `TX_A5,
                                  `TX_A4, `TX_A3, `TX_A2, `TX_A1, `TX_A0};
    localparam [31:0] HIGH_MIN_W = `TRIG_HIGH_MIN_CYC;
    localparam [7:0]  HIGH_MIN   = HIGH_MIN_W[7:0];

    wire        trigLevel;
    wire        trigRise;
    wire        trigFall;
    reg  [1:0]  exState;
    reg  [1:0]  next_exState;
    reg  [15:0] expCnt;
    reg  [15:0] next_expCnt;
    reg         expEnd;
    reg  [1:0]  rdState;
    reg  [1:0]  next_rdState;
    reg  [11:0] pixCnt;
    reg  [11:0] next_pixCnt;
    reg         pending;
    reg         next_pending;
    reg         next_overrun;
    reg  [7:0]  highCnt;
    wire [11:0] lastPix;
    wire [`TX_WIDTH-1:0] mapped;
    wire [`TX_WIDTH*11-1:0] mapAcc;

    // The trigger is the only camera control input to act on state
    trigger_sync u_trig (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .clkEn     (clkEn),
        .trigAsync (lineTrigger),
        .trigLevel (trigLevel),
        .trigRise  (trigRise),
        .trigFall  (trigFall)
    );

    // Pixel clock forwarded straight to the transmitter clock input
    assign txClk = ref_clk;

    // Exposure control: each mode ends one exposure per trigger period
    always @* begin
        next_exState = exState;
        next_expCnt  = expCnt;
        expEnd       = 1'b0;
        case (exState)
            EX_IDLE: begin
                if (expMode == `EXP_LEVEL) begin
                    if (trigFall) begin
                        next_exState = EX_RUN;
                    end
                end else if (trigRise) begin
                    next_exState = EX_RUN;
                    next_expCnt  = 16'h0000;
                end
            end
            EX_RUN: begin
                if (expMode == `EXP_LEVEL) begin
                    // Exposure lasts while the trigger is low
                    if (trigRise) begin
                        expEnd       = 1'b1;
                        next_exState = EX_IDLE;
                    end
                end else if (expMode == `EXP_PROG) begin
                    // Fixed exposure counted from the rising edge
                    if (clkEn) begin
                        next_expCnt = expCnt + 16'h0001;
                    end
                    if (clkEn && ({1'b0, expCnt} + 17'h00001 >= {1'b0, expTime})) begin
                        expEnd       = 1'b1;
                        next_exState = EX_IDLE;
                    end
                end else if (trigRise) begin
                    // Edge mode: each rising edge closes one exposure and
                    // opens the next, so exposure equals the period
                    expEnd       = 1'b1;
                    next_exState = EX_RUN;
                end
            end
            default: begin
                next_exState = EX_IDLE;
            end
        endcase
    end

    // Readout: a line of lineLength pixels, one per clock
    assign lastPix = (lineLength == 12'h000) ? 12'h000 : lineLength - 12'h001;
    assign pixReq  = clkEn & (rdState == RD_LINE);

    always @* begin
        next_rdState = rdState;
        next_pixCnt  = pixCnt;
        next_pending = pending;
        next_overrun = 1'b0;
        case (rdState)
            RD_IDLE: begin
                if (expEnd || pending) begin
                    next_rdState = RD_LINE;
                    next_pixCnt  = 12'h000;
                    next_pending = 1'b0;
                end
            end
            RD_LINE: begin
                if (clkEn) begin
                    if (pixCnt == lastPix) begin
                        next_pixCnt = 12'h000;
                        if (expEnd || pending) begin
                            // Back-to-back lines keep one line per trigger;
                            // an exposure ending now waits behind a pending one
                            next_pending = expEnd & pending;
                        end else begin
                            next_rdState = RD_IDLE;
                        end
                    end else begin
                        next_pixCnt = pixCnt + 12'h001;
                        if (expEnd) begin
                            // Only one finished exposure can wait; a second
                            // one while it waits is dropped and flagged
                            next_overrun = pending;
                            next_pending = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_rdState = RD_IDLE;
            end
        endcase
    end

    // Pixel bit mapping: one stage per source bit, OR-ed into place
    assign mapAcc[`TX_WIDTH-1:0] = {`TX_WIDTH{1'b0}};
    genvar gi;
    generate
        for (gi = 0; gi < `PIX_BITS; gi = gi + 1) begin : g_map
            wire pixBit;
            if (gi < 8) begin : g_a
                // 8-bit mode drops the two lowest bits
                assign pixBit = (outMode8 == `OUT_8BIT) ? pixIn[gi + 2] : pixIn[gi];
            end else begin : g_b
                // Port B only carries bits 8 and 9 in 10-bit mode
                assign pixBit = (outMode8 == `OUT_10BIT) & pixIn[gi];
            end
            assign mapAcc[(gi + 1) * `TX_WIDTH +: `TX_WIDTH] =
                mapAcc[gi * `TX_WIDTH +: `TX_WIDTH] |
                ({{(`TX_WIDTH - 1){1'b0}}, pixBit} << PORT_POS[gi * 5 +: 5]);
        end
    endgenerate

    // Valid bits at their fixed positions; 23 and 25 stay low
    assign mapped = mapAcc[`PIX_BITS * `TX_WIDTH +: `TX_WIDTH] |
                    ({{(`TX_WIDTH - 1){1'b0}}, 1'b1} << `TX_DVAL) |
                    ({{(`TX_WIDTH - 1){1'b0}}, 1'b1} << `TX_LVAL);

    // State and output registers
    always @(posedge ref_clk) begin
        if (srst) begin
            exState     <= EX_IDLE;
            expCnt      <= 16'h0000;
            rdState     <= RD_IDLE;
            pixCnt      <= 12'h000;
            pending     <= 1'b0;
            txData      <= `TX_RESET;
            exposing    <= 1'b0;
            lineOverrun <= 1'b0;
        end else if (clkEn) begin
            exState     <= next_exState;
            expCnt      <= next_expCnt;
            rdState     <= next_rdState;
            pixCnt      <= next_pixCnt;
            pending     <= next_pending;
            exposing    <= (next_exState == EX_RUN);
            lineOverrun <= next_overrun;
            // Valid bits and data change only on the rising edge
            if (pixReq) begin
                txData <= mapped;
            end else begin
                txData <= `TX_RESET;
            end
        end
    end

    // High phase shorter than the minimum is reported, not rejected,
    // since the line was already started by its rising edge
    always @(posedge ref_clk) begin
        if (srst) begin
            highCnt      <= 8'h00;
            trigTooShort <= 1'b0;
        end else if (clkEn) begin
            trigTooShort <= trigFall && (highCnt < HIGH_MIN);
            if (trigRise) begin
                highCnt <= 8'h01;
            end else if (trigLevel && highCnt != 8'hff) begin
                highCnt <= highCnt + 8'h01;
            end
        end
    end

endmodule

// [dv/line_camera_video_port_asserts.sv]
/* Checker for the video port: link word mapping, valid bits, reset.
   Assumes it is bound to line_camera_video_port and sees its ports only. */
`timescale 1ns/100ps
module line_camera_video_port_asserts (
    // Clock and control
    input wire        ref_clk,
    input wire        srst,
    input wire        clkEn,
    input wire        lineTrigger,
    input wire [1:0]  expMode,
    input wire        outMode8,
    // Pixel path and status
    input wire        pixReq,
    input wire [9:0]  pixIn,
    input wire        txClk,
    input wire [27:0] txData,
    input wire        exposing,
    input wire        trigTooShort,
    input wire        lineOverrun
);
    wire [9:0] pixMap = {txData[8], txData[7], txData[5], txData[27], txData[6], txData[4:0]};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_reset_clear: assert property (disable iff (1'b0) srst |=> txData == 28'h0 && !exposing)
        else $error("outputs not cleared by reset");
    a_valid_after_req: assert property (pixReq |=> txData[24] && txData[26])
        else $error("pixel taken without valid word");
    a_map_tenbit: assert property (pixReq && !outMode8 |=> pixMap == $past(pixIn))
        else $error("ten bit mapping wrong");
    a_map_eightbit: assert property (pixReq && outMode8 |=> pixMap == {2'h0, $past(pixIn[9:2])})
        else $error("eight bit mapping wrong");
    a_idle_no_valid: assert property (!pixReq |=> !txData[24])
        else $error("line valid without pixel");
    a_unused_low: assert property ((txData & 28'h2fffe00) == 28'h0)
        else $error("unused link input driven");
    a_valid_pair: assert property (txData[24] == txData[26])
        else $error("line and data valid differ");
    a_clk_fwd: assert property (@(negedge ref_clk) txClk)
        else $error("pixel clock not forwarded");
    a_trig_start: assert property (expMode == 2'h0 && clkEn && !exposing && $rose(lineTrigger)
        |-> ##[2:5] exposing)
        else $error("trigger edge did not start exposure");
    cover property (pixReq && outMode8);
    cover property (trigTooShort);
    cover property (lineOverrun);
    cover property (expMode == 2'h1 && $rose(exposing));
endmodule

bind line_camera_video_port line_camera_video_port_asserts chk (
    .ref_clk, .srst, .clkEn, .lineTrigger, .expMode, .outMode8, .pixReq,
    .pixIn, .txClk, .txData, .exposing, .trigTooShort, .lineOverrun
);

// [dv/frame_grabber_model.sv]
/* Frame grabber stand-in: drives the line trigger, counts lines and pixels.
   Assumes the camera forwards its pixel clock on txClk. */
`timescale 1ns/100ps
module frame_grabber_model (
    // Link from the camera
    input wire        txClk,
    input wire [27:0] txData,
    // Camera control
    output reg        lineTrigger,
    // Receive statistics
    output reg [15:0] lineCnt,
    output reg [15:0] wordCnt
);
    reg lvalLast;
    initial begin
        lineTrigger = 1'b0;
        lineCnt = 16'h0;
        wordCnt = 16'h0;
        lvalLast = 1'b0;
    end
    // Rising edge sampling; another receiver may use the falling one
    always @(posedge txClk) begin
        lvalLast <= txData[24];
        if (txData[24] && txData[26])
            wordCnt <= wordCnt + 16'h1;
        if (txData[24] && !lvalLast)
            lineCnt <= lineCnt + 16'h1;
    end
    // High below 100 ns breaks the minimum on purpose
    task pulse(input integer highNs, input integer lowNs);
        begin
            lineTrigger = 1'b1;
            #(highNs);
            lineTrigger = 1'b0;
            #(lowNs);
        end
    endtask
endmodule

// [dv/line_camera_video_port_tb.sv]
/* Testbench for the video port: exposure modes, line counts, short and static
   trigger, overrun. Assumes the bound checker and the grabber model. */
`timescale 1ns/100ps
module line_camera_video_port_tb;
    reg         ref_clk = 1'b0;
    reg         srst = 1'b1;
    reg         clkEn = 1'b1;
    reg  [1:0]  expMode = 2'h0;
    reg         outMode8 = 1'b0;
    reg  [15:0] expTime = 16'h0002;
    reg  [11:0] lineLength = 12'h003;
    reg  [9:0]  pixIn = 10'h155;
    wire        lineTrigger, pixReq, txClk, exposing, lineOverrun, trigTooShort;
    wire [27:0] txData;
    wire [15:0] lineCnt, wordCnt;
    integer     error_cnt = 0;
    integer     total_checks = 0;
    integer     seen;
    always #12.5 ref_clk = ~ref_clk;
    // Sensor stand-in; odd step reaches every pixel bit
    always @(posedge ref_clk) if (pixReq) pixIn <= pixIn + 10'h0d7;
    line_camera_video_port dut (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
        .lineTrigger(lineTrigger), .expMode(expMode), .outMode8(outMode8),
        .expTime(expTime), .lineLength(lineLength), .pixReq(pixReq), .pixIn(pixIn),
        .txClk(txClk), .txData(txData), .exposing(exposing),
        .lineOverrun(lineOverrun), .trigTooShort(trigTooShort));
    frame_grabber_model fg (.txClk(txClk), .txData(txData),
        .lineTrigger(lineTrigger), .lineCnt(lineCnt), .wordCnt(wordCnt));
    task check(input [8*8:1] what, input [27:0] exp, input [27:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task do_reset;
        begin
            srst <= 1'b1;
            repeat (2) @(posedge ref_clk);
            srst <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task run_mode(input [1:0] mode, input out8, input [15:0] expLines);
        reg [15:0] l0, w0;
        begin
            expMode <= mode;
            outMode8 <= out8;
            do_reset;
            l0 = lineCnt;
            w0 = wordCnt;
            #7;
            repeat (6) fg.pulse(100, 100);
            repeat (20) @(posedge ref_clk);
            check("lines", expLines, lineCnt - l0);
            check("words", expLines * 16'h3, wordCnt - w0);
        end
    endtask
    // Counts short-pulse flags around one trigger pulse
    task watch_short(input integer highNs);
        begin
            seen = 0;
            fork
                begin #7; fg.pulse(highNs, 200); end
                repeat (12) begin @(negedge ref_clk); if (trigTooShort === 1'b1) seen = seen + 1; end
            join
        end
    endtask
    task short_trigger;
        begin
            expMode <= 2'h0;
            do_reset;
            watch_short(50);
            check("short", 28'h1, seen);
            watch_short(100);
            check("minimum", 28'h0, seen);
        end
    endtask
    task static_high;
        reg [15:0] w0;
        begin
            do_reset;
            w0 = wordCnt;
            #7;
            fg.pulse(1500, 100);
            repeat (10) @(posedge ref_clk);
            check("static", w0, wordCnt);
        end
    endtask
    task overrun;
        begin
            lineLength <= 12'h028;
            do_reset;
            seen = 0;
            fork
                begin #7; repeat (8) fg.pulse(100, 100); end
                repeat (80) begin @(negedge ref_clk); if (lineOverrun === 1'b1) seen = 1; end
            join
            check("overrun", 28'h1, seen);
            lineLength <= 12'h003;
        end
    endtask
    // Triggers while the enable is low must leave no trace
    task freeze;
        reg [15:0] w0;
        begin
            do_reset;
            clkEn <= 1'b0;
            w0 = wordCnt;
            #7;
            repeat (3) fg.pulse(100, 100);
            @(posedge ref_clk);
            clkEn <= 1'b1;
            repeat (10) @(posedge ref_clk);
            check("frozen", w0, wordCnt);
            check("expose", 28'h0, exposing);
        end
    endtask
    task tally_and_finish;
        begin
            if (error_cnt == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("txData", 28'h0, txData);
        #3;
        check("txClk", 28'h1, txClk);
        @(negedge ref_clk);
        #3;
        check("txClk", 28'h0, txClk);
        @(posedge ref_clk);
        run_mode(2'h0, 1'b0, 16'h5);
        run_mode(2'h1, 1'b1, 16'h5);
        run_mode(2'h2, 1'b0, 16'h6);
        run_mode(2'h3, 1'b1, 16'h5);
        short_trigger;
        static_high;
        overrun;
        freeze;
        tally_and_finish;
    end
    // Whole run is about 13 microseconds
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
endmodule
